// file: logic/io_setup_pkg.sv
// Constants, codes and screen list for the I/O option setup block.
// Assumes a single 200 MHz core clock; shared by the design and its bench.
package io_setup_pkg;

    typedef enum logic [1:0] {MENU_SYSTEM, MENU_ANALOG, MENU_RELAY} menu_e;

    typedef enum logic [4:0] {
        ANALOG_OUT_TYPE_SCREEN,
        ANALOG_CH1_SOURCE_SCREEN,
        ANALOG_CH1_LOWER_SCREEN,
        ANALOG_CH1_UPPER_SCREEN,
        ANALOG_CH2_SOURCE_SCREEN,
        ANALOG_CH2_LOWER_SCREEN,
        ANALOG_CH2_UPPER_SCREEN,
        RELAY_CH1_MODE_SCREEN,
        RELAY_CH1_WIDTH_SCREEN,
        RELAY_CH1_QUANTITY_SCREEN,
        RELAY_CH1_COMPARE_SCREEN,
        RELAY_CH1_THRESHOLD_SCREEN,
        RELAY_CH1_DELAY_SCREEN,
        RELAY_CH2_MODE_SCREEN,
        RELAY_CH2_WIDTH_SCREEN,
        RELAY_CH2_QUANTITY_SCREEN,
        RELAY_CH2_COMPARE_SCREEN,
        RELAY_CH2_THRESHOLD_SCREEN,
        RELAY_CH2_DELAY_SCREEN
    } screen_e;

    localparam int NUM_SCREENS = 19;

    // Timing
    localparam int CLK_KHZ = 200000;
    localparam int HOLD_TIME_MS = 3000;
    localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_KHZ;
    localparam int MS_TIME_MS = 1;
    localparam int MS_CYCLES = MS_TIME_MS * CLK_KHZ;
    localparam int SEC_TIME_MS = 1000;
    localparam int SEC_CYCLES = SEC_TIME_MS * CLK_KHZ;

    // Analog output type codes
    localparam logic [1:0] AO_TYPE_0_5V = 2'h0;
    localparam logic [1:0] AO_TYPE_1_5V = 2'h1;
    localparam logic [1:0] AO_TYPE_0_20MA = 2'h2;
    localparam logic [1:0] AO_TYPE_4_20MA = 2'h3;
    // Analog source codes
    localparam logic [1:0] SRC_VOLT = 2'h0;
    localparam logic [1:0] SRC_CURR = 2'h1;
    localparam logic [1:0] SRC_POWER = 2'h2;
    // Limit sign codes
    localparam logic [1:0] SIGN_PLUS = 2'h0;
    localparam logic [1:0] SIGN_MINUS = 2'h1;
    localparam logic [1:0] SIGN_BOTH = 2'h2;
    // Relay mode, alarm quantity and comparison codes
    localparam logic [1:0] RLY_LATCH = 2'h0;
    localparam logic [1:0] RLY_MOMENT = 2'h1;
    localparam logic [1:0] RLY_ALARM = 2'h2;
    localparam logic [1:0] QTY_NONE = 2'h0;
    localparam logic [1:0] QTY_VOLT = 2'h1;
    localparam logic [1:0] QTY_CURR = 2'h2;
    localparam logic [1:0] QTY_POWER = 2'h3;
    localparam logic CMP_BELOW = 1'h0;
    localparam logic CMP_ABOVE = 1'h1;

    // Value ranges
    localparam logic [16:0] PCT_MAX = 17'h00064;
    localparam logic [16:0] WIDTH_MIN_MS = 17'h0012C;
    localparam logic [16:0] WIDTH_MAX_MS = 17'h01388;
    localparam logic [16:0] DELAY_MAX_S = 17'h000FF;
    localparam logic [16:0] THR_MAX_V = 17'h00BB8;
    localparam logic [16:0] THR_MAX_A = 17'h0C350;
    localparam logic [16:0] THR_MAX_KW = 17'h0EA60;

    // Relay screen offsets from a channel's mode screen
    localparam logic [4:0] RO_OFS_WIDTH = 5'h01;
    localparam logic [4:0] RO_OFS_QTY = 5'h02;
    localparam logic [4:0] RO_OFS_CMP = 5'h03;
    localparam logic [4:0] RO_OFS_THR = 5'h04;
    localparam logic [4:0] RO_OFS_DLY = 5'h05;

    localparam logic [2:0] SIGN_POS = 3'h5;

    // Reset values of settings (decimal digits)
    localparam logic [19:0] RST_VALUE_BCD = 20'h00000;
    localparam logic [19:0] RST_UPPER_BCD = 20'h00100;
    localparam logic [19:0] RST_WIDTH_BCD = 20'h00500;

    // Register offsets
    localparam logic [7:0] REG_RELAY_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_AO_CFG = 8'h08;
    localparam logic [7:0] REG_RO_CFG = 8'h0C;

    // Field positions
    localparam int CMD_LEVEL_LSB = 0;
    localparam int CMD_PULSE_LSB = 2;
    localparam int STAT_RELAY_LSB = 0;
    localparam int STAT_ALARM_LSB = 2;
    localparam int STAT_MENU_LSB = 4;
    localparam int STAT_SCREEN_LSB = 6;
    localparam int STAT_CURSOR_LSB = 11;
    localparam int AO_TYPE_LSB = 0;
    localparam int AO_SRC_LSB = 2;
    localparam int RO_MODE_LSB = 0;
    localparam int RO_QTY_LSB = 4;
    localparam int RO_CMP_LSB = 8;

endpackage : io_setup_pkg

// file: logic/io_setup.sv
// Menu engine and output behaviour of the analog/relay I/O option.
// Keys are raw active-low pins; SYS_MENU and measurements come from core logic.
//
// Notes on behaviour
// - From system menu, increment held 3 s enters analog, confirm held enters relay
// - Each increment press raises the flashing digit by one
// - Confirm moves cursor; on last digit commits and goes to next screen
// - Both keys together leave either output menu back to system menu
// - Two analog channels, source 0 voltage, 1 current, 2 power
// - Analog type codes 0..3 select 0-5V, 1-5V, 0-20mA, 4-20mA
// - Limit is sign digit plus percentage 0.00 to 1.00
// - Sign digit hidden for voltage source or zero percentage
// - Current or power limits allow three signed span modes
// - Reject zero upper limit or upper not above lower
// - Two relay channels, mode 0 latch, 1 momentary, 2 alarm
// - Momentary pulse width 300 to 5000 ms
// - Width screen only in mode 1, alarm screens only in mode 2
// - Alarm quantity 0 none, 1 voltage, 2 current, 3 power
// - Comparison 0 trips below threshold, 1 trips above
// - Threshold up to 3000 V, 50000 A, 60000 kW
// - Alarm delay 0 to 255 whole seconds
// - Alarm sets and clears only after condition held for the delay; leaving mode 2 clears it at once
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module io_setup
    import io_setup_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_CYCLES,
    parameter int MS_CYC = MS_CYCLES,
    parameter int SEC_CYC = SEC_CYCLES
)
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic KEY_INC_N,
    input wire logic KEY_CFM_N,
    input wire logic SYS_MENU,
    input wire logic [16:0] VOLT_MEAS,
    input wire logic [16:0] CURR_MEAS,
    input wire logic [16:0] POWER_MEAS,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IO_MENU_ACTIVE,
    output logic [1:0] MENU_MODE,
    output logic [4:0] DISP_SCREEN,
    output logic [2:0] DISP_CURSOR,
    output logic [19:0] DISP_DIGITS,
    output logic [1:0] DISP_SIGN,
    output logic DISP_SIGN_SHOWN,
    output logic [1:0] AO_TYPE,
    output logic [1:0][1:0] AO_SRC,
    output logic [1:0][6:0] AO_LO_PCT,
    output logic [1:0][1:0] AO_LO_SIGN,
    output logic [1:0][6:0] AO_HI_PCT,
    output logic [1:0][1:0] AO_HI_SIGN,
    output logic [1:0] RELAY_OUT,
    output logic [1:0] ALARM
);

    typedef struct packed {
        logic inc_m;
        logic inc_s;
        logic inc_p;
        logic cfm_m;
        logic cfm_s;
        logic cfm_p;
        logic combo;
        logic [31:0] hold;
        menu_e menu;
        screen_e scr;
        logic [2:0] cur;
        logic [19:0] ed;
        logic [1:0] esign;
        logic [NUM_SCREENS-1:0][19:0] val;
        logic [NUM_SCREENS-1:0][1:0] sgn;
        logic [1:0] lat;
        logic [1:0] pls;
        logic [1:0][31:0] pcyc;
        logic [1:0][16:0] pms;
        logic [1:0] alm;
        logic [1:0][31:0] acyc;
        logic [1:0][7:0] asec;
        logic [1:0] rly;
        logic [31:0] rdata;
    } state_s;

    state_s q;
    state_s d;

    function automatic logic [16:0] bcd2bin(input logic [19:0] b);
        return 17'(b[19:16]) * 17'd10000 + 17'(b[15:12]) * 17'd1000
            + 17'(b[11:8]) * 17'd100 + 17'(b[7:4]) * 17'd10 + 17'(b[3:0]);
    endfunction : bcd2bin

    function automatic logic [2:0] ndig(input screen_e s);
        case (s)
            ANALOG_CH1_LOWER_SCREEN, ANALOG_CH1_UPPER_SCREEN,
            ANALOG_CH2_LOWER_SCREEN, ANALOG_CH2_UPPER_SCREEN,
            RELAY_CH1_DELAY_SCREEN, RELAY_CH2_DELAY_SCREEN: return 3'h3;
            RELAY_CH1_WIDTH_SCREEN, RELAY_CH2_WIDTH_SCREEN: return 3'h4;
            RELAY_CH1_THRESHOLD_SCREEN, RELAY_CH2_THRESHOLD_SCREEN: return 3'h5;
            default: return 3'h1;
        endcase
    endfunction : ndig

    // Highest value a digit may take before wrapping to zero
    function automatic logic [3:0] dmax(input screen_e s, input logic [2:0] pos);
        case (s)
            ANALOG_OUT_TYPE_SCREEN: return 4'h3;
            ANALOG_CH1_SOURCE_SCREEN, ANALOG_CH2_SOURCE_SCREEN: return 4'h2;
            RELAY_CH1_MODE_SCREEN, RELAY_CH2_MODE_SCREEN: return 4'h2;
            RELAY_CH1_QUANTITY_SCREEN, RELAY_CH2_QUANTITY_SCREEN: return 4'h3;
            RELAY_CH1_COMPARE_SCREEN, RELAY_CH2_COMPARE_SCREEN: return 4'h1;
            ANALOG_CH1_LOWER_SCREEN, ANALOG_CH1_UPPER_SCREEN,
            ANALOG_CH2_LOWER_SCREEN, ANALOG_CH2_UPPER_SCREEN:
                return (pos == 3'h2) ? 4'h1 : 4'h9;
            default: return 4'h9;
        endcase
    endfunction : dmax

    // Next screen, wrapping within the group and skipping unused relay screens
    function automatic screen_e nxt(input screen_e s, input logic [1:0] m1,
                                    input logic [1:0] m2);
        case (s)
            ANALOG_CH2_UPPER_SCREEN: return ANALOG_OUT_TYPE_SCREEN;
            RELAY_CH1_MODE_SCREEN:
                return (m1 == RLY_MOMENT) ? RELAY_CH1_WIDTH_SCREEN :
                    (m1 == RLY_ALARM) ? RELAY_CH1_QUANTITY_SCREEN :
                    RELAY_CH2_MODE_SCREEN;
            RELAY_CH1_WIDTH_SCREEN, RELAY_CH1_DELAY_SCREEN: return RELAY_CH2_MODE_SCREEN;
            RELAY_CH2_MODE_SCREEN:
                return (m2 == RLY_MOMENT) ? RELAY_CH2_WIDTH_SCREEN :
                    (m2 == RLY_ALARM) ? RELAY_CH2_QUANTITY_SCREEN :
                    RELAY_CH1_MODE_SCREEN;
            RELAY_CH2_WIDTH_SCREEN, RELAY_CH2_DELAY_SCREEN: return RELAY_CH1_MODE_SCREEN;
            default: return screen_e'(5'(s) + 5'h01);
        endcase
    endfunction : nxt

    always_comb
    begin
        logic ki;
        logic kc;
        logic inc_ev;
        logic cfm_ev;
        logic both_ev;
        logic load;
        logic lim;
        logic is_hi;
        logic vis;
        logic ok;
        logic [1:0] src;
        logic [3:0] dig;
        logic [16:0] v;
        logic [16:0] tmax;
        logic [4:0] rb;
        logic [1:0] rmode;
        logic [1:0] qty;
        logic [16:0] width;
        logic [16:0] thr;
        logic [16:0] dly;
        logic [16:0] meas;
        logic cond;
        ki = 1'b0;
        kc = 1'b0;
        inc_ev = 1'b0;
        cfm_ev = 1'b0;
        both_ev = 1'b0;
        load = 1'b0;
        lim = 1'b0;
        is_hi = 1'b0;
        vis = 1'b0;
        ok = 1'b1;
        src = SRC_VOLT;
        dig = 4'h0;
        v = 17'h00000;
        tmax = 17'h00000;
        rb = 5'h00;
        rmode = RLY_LATCH;
        qty = QTY_NONE;
        width = 17'h00000;
        thr = 17'h00000;
        dly = 17'h00000;
        meas = 17'h00000;
        cond = 1'b0;
        d = q;

        // Key synchronisers and press detection; a press acts on release
        d.inc_m = ~KEY_INC_N;
        d.inc_s = q.inc_m;
        d.inc_p = q.inc_s;
        d.cfm_m = ~KEY_CFM_N;
        d.cfm_s = q.cfm_m;
        d.cfm_p = q.cfm_s;
        ki = q.inc_s;
        kc = q.cfm_s;
        inc_ev = q.inc_p & ~q.cfm_p & ~ki & ~kc & ~q.combo;
        cfm_ev = q.cfm_p & ~q.inc_p & ~ki & ~kc & ~q.combo;
        both_ev = ki & kc & ~(q.inc_p & q.cfm_p);
        if (ki && kc)
        begin
            d.combo = 1'b1;
        end
        else if (!ki && !kc)
        begin
            d.combo = 1'b0;
        end

        // Long hold in the system menu enters an output menu
        if (q.menu == MENU_SYSTEM && SYS_MENU && (ki ^ kc) && !q.combo)
        begin
            if (q.hold == 32'(HOLD_CYC - 1))
            begin
                d.hold = 32'h00000000;
                d.combo = 1'b1;
                d.menu = ki ? MENU_ANALOG : MENU_RELAY;
                d.scr = ki ? ANALOG_OUT_TYPE_SCREEN : RELAY_CH1_MODE_SCREEN;
                load = 1'b1;
            end
            else
            begin
                d.hold = q.hold + 32'h00000001;
            end
        end
        else
        begin
            d.hold = 32'h00000000;
        end

        // Sign digit visibility of the screen being edited
        lim = (q.scr == ANALOG_CH1_LOWER_SCREEN) || (q.scr == ANALOG_CH1_UPPER_SCREEN)
            || (q.scr == ANALOG_CH2_LOWER_SCREEN) || (q.scr == ANALOG_CH2_UPPER_SCREEN);
        is_hi = (q.scr == ANALOG_CH1_UPPER_SCREEN) || (q.scr == ANALOG_CH2_UPPER_SCREEN);
        src = (5'(q.scr) < 5'(ANALOG_CH2_SOURCE_SCREEN)) ?
            q.val[ANALOG_CH1_SOURCE_SCREEN][1:0] : q.val[ANALOG_CH2_SOURCE_SCREEN][1:0];
        vis = lim && (src != SRC_VOLT) && (q.ed != 20'h00000);

        if (q.menu != MENU_SYSTEM)
        begin
            if (both_ev)
            begin
                d.menu = MENU_SYSTEM;
            end
            else if (inc_ev)
            begin
                if (q.cur == SIGN_POS)
                begin
                    d.esign = (q.esign == SIGN_BOTH) ? SIGN_PLUS : q.esign + 2'h1;
                end
                else
                begin
                    dig = q.ed[q.cur*4 +: 4];
                    d.ed[q.cur*4 +: 4] = (dig >= dmax(q.scr, q.cur)) ? 4'h0 : dig + 4'h1;
                end
            end
            else if (cfm_ev)
            begin
                if (q.cur == SIGN_POS || (q.cur == 3'h0 && !vis))
                begin
                    v = bcd2bin(q.ed);
                    tmax = (q.val[5'(q.scr) - RO_OFS_THR + RO_OFS_QTY][1:0] == QTY_VOLT) ?
                        THR_MAX_V : (q.val[5'(q.scr) - RO_OFS_THR + RO_OFS_QTY][1:0]
                        == QTY_CURR) ? THR_MAX_A : THR_MAX_KW;
                    case (q.scr)
                        RELAY_CH1_WIDTH_SCREEN, RELAY_CH2_WIDTH_SCREEN:
                            ok = (v >= WIDTH_MIN_MS) && (v <= WIDTH_MAX_MS);
                        RELAY_CH1_THRESHOLD_SCREEN, RELAY_CH2_THRESHOLD_SCREEN:
                            ok = (v <= tmax);
                        RELAY_CH1_DELAY_SCREEN, RELAY_CH2_DELAY_SCREEN:
                            ok = (v <= DELAY_MAX_S);
                        default:
                            ok = !lim || (v <= PCT_MAX);
                    endcase
                    if (is_hi && (v == 17'h00000 || v <= bcd2bin(q.val[5'(q.scr) - 5'h01])))
                    begin
                        ok = 1'b0;
                    end
                    if (ok)
                    begin
                        d.val[q.scr] = q.ed;
                        d.sgn[q.scr] = vis ? q.esign : SIGN_PLUS;
                        d.scr = nxt(q.scr, d.val[RELAY_CH1_MODE_SCREEN][1:0],
                                    d.val[RELAY_CH2_MODE_SCREEN][1:0]);
                    end
                    load = 1'b1;
                end
                else if (q.cur == 3'h0)
                begin
                    d.cur = SIGN_POS;
                end
                else
                begin
                    d.cur = q.cur - 3'h1;
                end
            end
        end

        // Open a screen with its stored value, cursor on the leading digit
        if (load)
        begin
            d.ed = d.val[d.scr];
            d.esign = d.sgn[d.scr];
            d.cur = ndig(d.scr) - 3'h1;
        end

        if (WR && ADDR == REG_RELAY_CMD)
        begin
            d.lat = WDATA[CMD_LEVEL_LSB +: 2];
        end

        for (int ch = 0; ch < 2; ch++)
        begin
            rb = (ch == 0) ? 5'(RELAY_CH1_MODE_SCREEN) : 5'(RELAY_CH2_MODE_SCREEN);
            rmode = q.val[rb][1:0];
            width = bcd2bin(q.val[rb + RO_OFS_WIDTH]);
            qty = q.val[rb + RO_OFS_QTY][1:0];
            thr = bcd2bin(q.val[rb + RO_OFS_THR]);
            dly = bcd2bin(q.val[rb + RO_OFS_DLY]);
            meas = (qty == QTY_VOLT) ? VOLT_MEAS : (qty == QTY_CURR) ? CURR_MEAS : POWER_MEAS;
            cond = (qty != QTY_NONE) &&
                ((q.val[rb + RO_OFS_CMP][0] == CMP_ABOVE) ? (meas > thr) : (meas < thr));

            // In mode 2 the alarm follows the condition only after it differs for the whole delay; other modes clear it at once
            if (rmode != RLY_ALARM || cond == q.alm[ch])
            begin
                d.alm[ch] = (rmode == RLY_ALARM) ? q.alm[ch] : 1'b0;
                d.acyc[ch] = 32'h00000000;
                d.asec[ch] = 8'h00;
            end
            else if (17'(q.asec[ch]) >= dly)
            begin
                d.alm[ch] = cond;
                d.acyc[ch] = 32'h00000000;
                d.asec[ch] = 8'h00;
            end
            else if (q.acyc[ch] == 32'(SEC_CYC - 1))
            begin
                d.acyc[ch] = 32'h00000000;
                d.asec[ch] = q.asec[ch] + 8'h01;
            end
            else
            begin
                d.acyc[ch] = q.acyc[ch] + 32'h00000001;
            end

            // Momentary pulse, retriggered by a fresh command
            if (WR && ADDR == REG_RELAY_CMD && WDATA[CMD_PULSE_LSB + ch])
            begin
                d.pls[ch] = 1'b1;
                d.pcyc[ch] = 32'h00000000;
                d.pms[ch] = 17'h00000;
            end
            else if (q.pls[ch])
            begin
                if (q.pms[ch] >= width)
                begin
                    d.pls[ch] = 1'b0;
                end
                else if (q.pcyc[ch] == 32'(MS_CYC - 1))
                begin
                    d.pcyc[ch] = 32'h00000000;
                    d.pms[ch] = q.pms[ch] + 17'h00001;
                end
                else
                begin
                    d.pcyc[ch] = q.pcyc[ch] + 32'h00000001;
                end
            end

            case (rmode)
                RLY_LATCH: d.rly[ch] = q.lat[ch];
                RLY_MOMENT: d.rly[ch] = q.pls[ch];
                RLY_ALARM: d.rly[ch] = q.alm[ch];
                default: d.rly[ch] = 1'b0;
            endcase
        end

        d.rdata = 32'h00000000;
        if (RD)
        begin
            case (ADDR)
                REG_RELAY_CMD: d.rdata[CMD_LEVEL_LSB +: 2] = q.lat;
                REG_STATUS:
                begin
                    d.rdata[STAT_RELAY_LSB +: 2] = q.rly;
                    d.rdata[STAT_ALARM_LSB +: 2] = q.alm;
                    d.rdata[STAT_MENU_LSB +: 2] = q.menu;
                    d.rdata[STAT_SCREEN_LSB +: 5] = q.scr;
                    d.rdata[STAT_CURSOR_LSB +: 3] = q.cur;
                end
                REG_AO_CFG:
                begin
                    d.rdata[AO_TYPE_LSB +: 2] = q.val[ANALOG_OUT_TYPE_SCREEN][1:0];
                    d.rdata[AO_SRC_LSB +: 2] = q.val[ANALOG_CH1_SOURCE_SCREEN][1:0];
                    d.rdata[AO_SRC_LSB + 2 +: 2] = q.val[ANALOG_CH2_SOURCE_SCREEN][1:0];
                end
                REG_RO_CFG:
                begin
                    d.rdata[RO_MODE_LSB +: 2] = q.val[RELAY_CH1_MODE_SCREEN][1:0];
                    d.rdata[RO_MODE_LSB + 2 +: 2] = q.val[RELAY_CH2_MODE_SCREEN][1:0];
                    d.rdata[RO_QTY_LSB +: 2] = q.val[RELAY_CH1_QUANTITY_SCREEN][1:0];
                    d.rdata[RO_QTY_LSB + 2 +: 2] = q.val[RELAY_CH2_QUANTITY_SCREEN][1:0];
                    d.rdata[RO_CMP_LSB] = q.val[RELAY_CH1_COMPARE_SCREEN][0];
                    d.rdata[RO_CMP_LSB + 1] = q.val[RELAY_CH2_COMPARE_SCREEN][0];
                end
                default: d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            q <= '0;
            q.menu <= MENU_SYSTEM;
            q.scr <= ANALOG_OUT_TYPE_SCREEN;
            for (int i = 0; i < NUM_SCREENS; i++)
            begin
                q.val[i] <= RST_VALUE_BCD;
                q.sgn[i] <= SIGN_PLUS;
            end
            q.val[ANALOG_CH1_UPPER_SCREEN] <= RST_UPPER_BCD;
            q.val[ANALOG_CH2_UPPER_SCREEN] <= RST_UPPER_BCD;
            q.val[RELAY_CH1_WIDTH_SCREEN] <= RST_WIDTH_BCD;
            q.val[RELAY_CH2_WIDTH_SCREEN] <= RST_WIDTH_BCD;
        end
        else
        begin
            q <= d;
        end
    end

    assign RDATA = q.rdata;
    assign IO_MENU_ACTIVE = (q.menu != MENU_SYSTEM);
    assign MENU_MODE = q.menu;
    assign DISP_SCREEN = q.scr;
    assign DISP_CURSOR = q.cur;
    assign DISP_DIGITS = q.ed;
    assign DISP_SIGN = q.esign;
    assign DISP_SIGN_SHOWN = (q.menu != MENU_SYSTEM) &&
        ((q.scr == ANALOG_CH1_LOWER_SCREEN) || (q.scr == ANALOG_CH1_UPPER_SCREEN)
        || (q.scr == ANALOG_CH2_LOWER_SCREEN) || (q.scr == ANALOG_CH2_UPPER_SCREEN))
        && (((5'(q.scr) < 5'(ANALOG_CH2_SOURCE_SCREEN)) ?
        q.val[ANALOG_CH1_SOURCE_SCREEN][1:0] : q.val[ANALOG_CH2_SOURCE_SCREEN][1:0])
        != SRC_VOLT) && (q.ed != 20'h00000);
    assign AO_TYPE = q.val[ANALOG_OUT_TYPE_SCREEN][1:0];
    assign AO_SRC[0] = q.val[ANALOG_CH1_SOURCE_SCREEN][1:0];
    assign AO_SRC[1] = q.val[ANALOG_CH2_SOURCE_SCREEN][1:0];
    assign AO_LO_PCT[0] = 7'(bcd2bin(q.val[ANALOG_CH1_LOWER_SCREEN]));
    assign AO_LO_PCT[1] = 7'(bcd2bin(q.val[ANALOG_CH2_LOWER_SCREEN]));
    assign AO_HI_PCT[0] = 7'(bcd2bin(q.val[ANALOG_CH1_UPPER_SCREEN]));
    assign AO_HI_PCT[1] = 7'(bcd2bin(q.val[ANALOG_CH2_UPPER_SCREEN]));
    assign AO_LO_SIGN[0] = q.sgn[ANALOG_CH1_LOWER_SCREEN];
    assign AO_LO_SIGN[1] = q.sgn[ANALOG_CH2_LOWER_SCREEN];
    assign AO_HI_SIGN[0] = q.sgn[ANALOG_CH1_UPPER_SCREEN];
    assign AO_HI_SIGN[1] = q.sgn[ANALOG_CH2_UPPER_SCREEN];
    assign RELAY_OUT = q.rly;
    assign ALARM = q.alm;

endmodule : io_setup
`default_nettype wire

// file: verification/io_setup_monitor.sv
// Port-level checker for io_setup: menu, display, settings and bus.
// Assumes it is bound to io_setup and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module io_setup_monitor
    import io_setup_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic KEY_INC_N,
    input wire logic KEY_CFM_N,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic IO_MENU_ACTIVE,
    input wire logic [1:0] MENU_MODE,
    input wire logic [4:0] DISP_SCREEN,
    input wire logic [2:0] DISP_CURSOR,
    input wire logic [19:0] DISP_DIGITS,
    input wire logic DISP_SIGN_SHOWN,
    input wire logic [1:0] AO_TYPE,
    input wire logic [1:0][6:0] AO_LO_PCT,
    input wire logic [1:0][6:0] AO_HI_PCT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_both;
        (!KEY_INC_N && !KEY_CFM_N) [*3];
    endsequence
    property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
    property p_active; IO_MENU_ACTIVE == (MENU_MODE != MENU_SYSTEM); endproperty
    property p_cursor; DISP_CURSOR <= SIGN_POS; endproperty
    property p_sign; DISP_SIGN_SHOWN |-> DISP_DIGITS != RST_VALUE_BCD; endproperty
    property p_pct; AO_LO_PCT[0] <= 7'h64 && AO_LO_PCT[1] <= 7'h64; endproperty
    property p_upper; AO_HI_PCT[0] != 7'h00 && AO_HI_PCT[1] != 7'h00; endproperty
    property p_type; $changed(AO_TYPE) |-> $past(MENU_MODE) == MENU_ANALOG; endproperty
    property p_exit; s_both |-> ##[1:3] MENU_MODE == MENU_SYSTEM; endproperty
    property p_relay_scr; MENU_MODE == MENU_RELAY |-> DISP_SCREEN >= RELAY_CH1_MODE_SCREEN;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    a_active: assert property (p_active) else $error("menu active flag wrong");
    a_cursor: assert property (p_cursor) else $error("cursor out of range");
    a_sign: assert property (p_sign) else $error("sign shown on zero value");
    a_pct: assert property (p_pct) else $error("lower limit above full range");
    a_upper: assert property (p_upper) else $error("upper limit zero");
    a_type: assert property (p_type) else $error("type changed outside menu");
    a_exit: assert property (p_exit) else $error("both keys did not exit");
    a_relay_scr: assert property (p_relay_scr) else $error("relay menu off screen");
endmodule : io_setup_monitor
`default_nettype wire

// file: verification/io_setup_tb_top.sv
// Self-checking bench for io_setup.
// Assumes shortened hold, millisecond and second counts.
`timescale 1ns/100ps
`default_nettype none
module io_setup_tb_top;
    import io_setup_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic kin = 1'b1;
    logic sysm = 1'b0;
    logic [16:0] vmeas = 17'h0;
    logic kcf = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [1:0] mode, aot, rly, alm;
    logic [4:0] scr;
    logic [19:0] dig;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    io_setup #(.HOLD_CYC(20), .MS_CYC(4), .SEC_CYC(10)) DUT (.CORE_CLK(clk), .RSTN(rstn),
        .KEY_INC_N(kin), .KEY_CFM_N(kcf), .SYS_MENU(sysm), .VOLT_MEAS(vmeas),
        .CURR_MEAS(17'h0), .POWER_MEAS(17'h0), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IO_MENU_ACTIVE(), .MENU_MODE(mode), .DISP_SCREEN(scr),
        .DISP_CURSOR(), .DISP_DIGITS(dig), .DISP_SIGN(), .DISP_SIGN_SHOWN(), .AO_TYPE(aot),
        .AO_SRC(), .AO_LO_PCT(), .AO_LO_SIGN(), .AO_HI_PCT(), .AO_HI_SIGN(),
        .RELAY_OUT(rly), .ALARM(alm));
    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask : rd_reg
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic key(input logic i, input logic c, input int n);
        kin <= ~i;
        kcf <= ~c;
        repeat (n) @(posedge clk);
        kin <= 1'b1;
        kcf <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : key
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(REG_AO_CFG, 32'h0, "ao_cfg reset");
        rd_reg(8'h10, 32'h0, "unmapped");
        key(1'b1, 1'b0, 30);
        chk("no entry", 32'(MENU_SYSTEM), 32'(mode));
        sysm <= 1'b1;
        key(1'b1, 1'b0, 30);
        chk("analog menu", 32'(MENU_ANALOG), 32'(mode));
        repeat (3) key(1'b1, 1'b0, 2);
        chk("type digit", 32'h3, 32'(dig));
        key(1'b0, 1'b1, 2);
        chk("type", 32'(AO_TYPE_4_20MA), 32'(aot));
        chk("next screen", 32'(ANALOG_CH1_SOURCE_SCREEN), 32'(scr));
        key(1'b1, 1'b1, 4);
        chk("exit", 32'(MENU_SYSTEM), 32'(mode));
        key(1'b0, 1'b1, 30);
        chk("relay screen", 32'(RELAY_CH1_MODE_SCREEN), 32'(scr));
        key(1'b1, 1'b0, 2);
        key(1'b0, 1'b1, 2);
        chk("width screen", 32'(RELAY_CH1_WIDTH_SCREEN), 32'(scr));
        rd_reg(REG_RO_CFG, {30'h0, RLY_MOMENT}, "ro_cfg");
        wr_reg(REG_RELAY_CMD, 32'h6);
        repeat (10) @(posedge clk);
        chk("pulse on", 32'h3, 32'(rly));
        repeat (1980) @(posedge clk);
        #1 chk("held", 32'h3, 32'(rly));
        repeat (20) @(posedge clk);
        chk("pulse off", 32'h2, 32'(rly));
        rd_reg(REG_RELAY_CMD, 32'h2, "latch level");
        repeat (4) key(1'b0, 1'b1, 2);
        repeat (2) key(1'b1, 1'b0, 2);
        key(1'b0, 1'b1, 2);
        key(1'b1, 1'b0, 2);
        key(1'b0, 1'b1, 2);
        key(1'b1, 1'b0, 2);
        repeat (8) key(1'b0, 1'b1, 2);
        key(1'b1, 1'b0, 2);
        key(1'b0, 1'b1, 2);
        vmeas <= 17'h5;
        repeat (5) @(posedge clk);
        #1 chk("alarm off", 32'h0, 32'(alm));
        repeat (20) @(posedge clk);
        #1 chk("alarm on", 32'h2, 32'(alm));
        give_verdict();
    end
endmodule : io_setup_tb_top
bind io_setup io_setup_monitor mon (.CORE_CLK, .RSTN, .KEY_INC_N, .KEY_CFM_N, .RD, .RDATA,
    .IO_MENU_ACTIVE, .MENU_MODE, .DISP_SCREEN, .DISP_CURSOR, .DISP_DIGITS, .DISP_SIGN_SHOWN,
    .AO_TYPE, .AO_LO_PCT, .AO_HI_PCT);
`default_nettype wire
